// *** rsc_core.sv ***
/*
  rsc_core: smooth digital calibration of the kernel clock, asynchronous
  prescaler fed by the corrected pulses, and timestamp capture with flag,
  overflow and interrupt, behind a classic Wishbone slave.
  assumes: kernel clock and timestamp pin are asynchronous and far slower
  than clk_sys_in; calendar inputs and tamper event come from clk_sys_in logic.
*/
`default_nettype none
module rsc_core
  import rsc_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          clk_sys_in,
  input  wire logic          rst_b_in,
  input  wire logic          rtc_kernel_clock_in,
  input  wire logic          stamp_pin_in,
  input  wire logic          tamper_event_in,
  input  wire logic [15:0]   cal_subsec_in,
  input  wire logic [31:0]   cal_time_in,
  input  wire logic [31:0]   cal_date_in,
  input  wire logic          wb_cyc_in,
  input  wire logic          wb_stb_in,
  input  wire logic          wb_we_in,
  input  wire logic [AW-1:0] wb_adr_in,
  input  wire logic [3:0]    wb_sel_in,
  input  wire logic [31:0]   wb_dat_in,
  output logic [31:0]        wb_dat_out,
  output logic               wb_ack_out,
  output logic               stamp_irq_out,
  output logic               kernel_pulse_out,
  output logic               async_prescaler_clock_out
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  logic [2:0]           kern_sync;
  logic [2:0]           pin_sync;
  logic                 kern_tick;
  logic                 pin_edge;
  logic [CAL_CNT_W-1:0] cal_cnt;
  logic [CAL_CNT_W-1:0] next_cal_cnt;
  logic                 ins_pend;
  logic                 mask_hit;
  logic                 ins_hit;
  logic                 corr_pulse;
  logic [ASYNC_W-1:0]   apre_cnt;
  logic                 apre_tick;
  logic [4:0]           ctrl;
  logic [ASYNC_W-1:0]   async_divider_value;
  logic [MASK_W-1:0]    masked_pulse_count;
  logic                 cycle_16s_select;
  logic                 cycle_8s_select;
  logic                 pulse_insert_enable;
  logic [MASK_W-1:0]    act_mask;
  logic                 act_w16;
  logic                 act_w8;
  logic                 act_insert;
  logic                 ins_eff;
  logic [MASK_W-1:0]    mask_forced;
  logic                 recal_pending_flag;
  logic [1:0]           recal_cnt;
  logic                 cal_wr_d;
  logic                 load_cal;
  logic                 init_mode_flag;
  rsc_ts_state_type     ts_state;
  logic [1:0]           ts_cnt;
  logic                 stamp_flag;
  logic                 stamp_overflow_flag;
  logic                 stamp_event;
  logic                 stamp_busy;
  logic                 stamp_set;
  logic                 flag_clr;
  logic                 ovf_clr;
  logic [15:0]          stamp_sub;
  logic [31:0]          stamp_time;
  logic [31:0]          stamp_date;
  logic                 bus_wr;
  logic [31:0]          rd_data;
  logic [31:0]          cal_word;
  logic [31:0]          ctrl_merged;
  logic [31:0]          div_merged;

  // kernel clock and pin are asynchronous: two flops before any use
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      kern_sync <= 3'h0;
      pin_sync  <= 3'h0;
    end else begin
      kern_sync <= {kern_sync[1:0], rtc_kernel_clock_in};
      pin_sync  <= {pin_sync[1:0], stamp_pin_in};
    end
  end

  assign kern_tick = kern_sync[1] & ~kern_sync[2];
  assign pin_edge  = ctrl[CTRL_FALL] ? (pin_sync[2] & ~pin_sync[1])
                                     : (pin_sync[1] & ~pin_sync[2]);

  assign init_mode_flag = ctrl[CTRL_INIT];
  assign ins_eff        = act_insert & (async_divider_value >= INSERT_MIN_DIV);
  assign bus_wr         = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
  assign ctrl_merged    = merge({27'h0, ctrl}, wb_dat_in, wb_sel_in);
  assign div_merged     = merge({25'h0, async_divider_value}, wb_dat_in, wb_sel_in);

  // mask bit n hits where the counter's low 20-n bits equal 1 followed by zeros
  always_comb begin
    logic [CAL_CNT_W-1:0] low_m;
    logic [CAL_CNT_W-1:0] pos;
    low_m    = '0;
    pos      = '0;
    mask_hit = 1'b0;
    for (int n = 0; n < MASK_W; n++) begin
      low_m = 20'hFFFFF >> n;
      pos   = 20'h80000 >> n;
      if (act_mask[n] && ((cal_cnt & low_m) == pos)) begin
        mask_hit = 1'b1;
      end
    end
    ins_hit = ins_eff && (cal_cnt[INSERT_SHIFT-1:0] == '0);
  end

  // shortened cycles wrap the counter early
  always_comb begin
    next_cal_cnt = cal_cnt + 20'h00001;
    if (act_w16 | act_w8) begin
      next_cal_cnt[19] = 1'b0;
    end
    if (act_w8) begin
      next_cal_cnt[18] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_cnt <= '0;
    end else if (kern_tick) begin
      cal_cnt <= next_cal_cnt;
    end
  end

  // mask and insert together cancel; an insert alone adds a pulse one cycle later
  assign corr_pulse = (kern_tick & (~mask_hit | ins_hit)) | ins_pend;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ins_pend <= 1'b0;
    end else begin
      ins_pend <= kern_tick & ~mask_hit & ins_hit;
    end
  end

  assign apre_tick = corr_pulse && (apre_cnt == async_divider_value);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      apre_cnt                  <= '0;
      kernel_pulse_out          <= 1'b0;
      async_prescaler_clock_out <= 1'b0;
    end else begin
      if (apre_tick) begin
        apre_cnt <= '0;
      end else if (corr_pulse) begin
        apre_cnt <= apre_cnt + 7'h01;
      end
      kernel_pulse_out          <= corr_pulse;
      async_prescaler_clock_out <= apre_tick;
    end
  end

  // register writes take effect at the edge where the master samples ack
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl                <= CTRL_RST;
      async_divider_value <= ASYNC_DIV_RST;
    end else if (bus_wr) begin
      if (wb_adr_in == OFS_CTRL) begin
        ctrl <= ctrl_merged[4:0];
      end else if (wb_adr_in == OFS_PRESCALE) begin
        async_divider_value <= div_merged[6:0];
      end
    end
  end

  // forced mask bits read and act as zero
  always_comb begin
    mask_forced = masked_pulse_count;
    if (cycle_16s_select | cycle_8s_select) begin
      mask_forced[0] = 1'b0;
    end
    if (cycle_8s_select) begin
      mask_forced[1] = 1'b0;
    end
    cal_word                                  = 32'h0;
    cal_word[CAL_MASK_LSB +: MASK_W]          = mask_forced;
    cal_word[CAL_W16]                         = cycle_16s_select;
    cal_word[CAL_W8]                          = cycle_8s_select;
    cal_word[CAL_INSERT]                      = pulse_insert_enable;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      masked_pulse_count  <= '0;
      cycle_16s_select    <= 1'b0;
      cycle_8s_select     <= 1'b0;
      pulse_insert_enable <= 1'b0;
      cal_wr_d            <= 1'b0;
    end else begin
      cal_wr_d <= bus_wr && (wb_adr_in == OFS_CAL);
      if (bus_wr && (wb_adr_in == OFS_CAL)) begin
        if (wb_sel_in[0]) begin
          masked_pulse_count[7:0] <= wb_dat_in[7:0];
        end
        if (wb_sel_in[1]) begin
          masked_pulse_count[8] <= wb_dat_in[8];
          cycle_16s_select      <= wb_dat_in[CAL_W16];
          cycle_8s_select       <= wb_dat_in[CAL_W8];
          pulse_insert_enable   <= wb_dat_in[CAL_INSERT] & (async_divider_value >= INSERT_MIN_DIV);
        end
      end
    end
  end

  // in init mode the new setting loads the cycle after the write, otherwise on the second prescaler tick
  assign load_cal = (cal_wr_d & init_mode_flag)
                  | (recal_pending_flag & apre_tick & (recal_cnt == RECAL_LOAD_TK - 2'h1));

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      recal_pending_flag <= 1'b0;
      recal_cnt          <= 2'h0;
    end else if (cal_wr_d & ~init_mode_flag) begin
      recal_pending_flag <= 1'b1;
      recal_cnt          <= 2'h0;
    end else if (load_cal) begin
      recal_pending_flag <= 1'b0;
    end else if (recal_pending_flag & apre_tick) begin
      recal_cnt <= recal_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_mask   <= '0;
      act_w16    <= 1'b0;
      act_w8     <= 1'b0;
      act_insert <= 1'b0;
    end else if (load_cal) begin
      act_mask   <= mask_forced;
      act_w16    <= cycle_16s_select;
      act_w8     <= cycle_8s_select;
      act_insert <= pulse_insert_enable;
    end
  end

  assign stamp_event = (ctrl[CTRL_STAMP_EN] & pin_edge) | (ctrl[CTRL_TAMP_STAMP] & tamper_event_in);
  assign stamp_busy  = stamp_flag | (ts_state == TS_WAIT);
  assign stamp_set   = (ts_state == TS_WAIT) & apre_tick & (ts_cnt == STAMP_SYNC_TK - 2'h1);
  assign flag_clr    = bus_wr && (wb_adr_in == OFS_STATUS) && wb_sel_in[0] && !wb_dat_in[STS_FLAG];
  assign ovf_clr     = bus_wr && (wb_adr_in == OFS_STATUS) && wb_sel_in[0] && !wb_dat_in[STS_OVF];

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ts_state   <= TS_IDLE;
      ts_cnt     <= 2'h0;
      stamp_sub  <= 16'h0000;
      stamp_time <= 32'h0;
      stamp_date <= 32'h0;
    end else begin
      case (ts_state)
        TS_IDLE: begin
          if (stamp_event & ~stamp_busy) begin
            stamp_sub  <= cal_subsec_in;
            stamp_time <= cal_time_in;
            stamp_date <= cal_date_in;
            ts_cnt     <= 2'h0;
            ts_state   <= TS_WAIT;
          end
        end
        TS_WAIT: begin
          if (stamp_set) begin
            ts_state <= TS_IDLE;
          end else if (apre_tick) begin
            ts_cnt <= ts_cnt + 2'h1;
          end
        end
        default: begin
          ts_state <= TS_IDLE;
        end
      endcase
    end
  end

  // an event in the clear cycle keeps the flag: set wins over clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stamp_flag          <= 1'b0;
      stamp_overflow_flag <= 1'b0;
      stamp_irq_out       <= 1'b0;
    end else begin
      if (stamp_set | (stamp_event & stamp_flag)) begin
        stamp_flag <= 1'b1;
      end else if (flag_clr) begin
        stamp_flag <= 1'b0;
      end
      if (stamp_event & stamp_busy) begin
        stamp_overflow_flag <= 1'b1;
      end else if (ovf_clr) begin
        stamp_overflow_flag <= 1'b0;
      end
      stamp_irq_out <= stamp_set & ctrl[CTRL_IRQ_EN];
    end
  end

  always_comb begin
    rd_data = 32'h0;
    if (wb_adr_in == OFS_CTRL) begin
      rd_data[4:0] = ctrl;
    end else if (wb_adr_in == OFS_STATUS) begin
      rd_data[STS_INIT]  = init_mode_flag;
      rd_data[STS_RECAL] = recal_pending_flag;
      rd_data[STS_FLAG]  = stamp_flag;
      rd_data[STS_OVF]   = stamp_overflow_flag;
    end else if (wb_adr_in == OFS_CAL) begin
      rd_data = cal_word;
    end else if (wb_adr_in == OFS_PRESCALE) begin
      rd_data[6:0] = async_divider_value;
    end else if (wb_adr_in == OFS_STAMP_SUB) begin
      rd_data[15:0] = stamp_sub;
    end else if (wb_adr_in == OFS_STAMP_TIME) begin
      rd_data = stamp_time;
    end else if (wb_adr_in == OFS_STAMP_DATE) begin
      rd_data = stamp_date;
    end
  end

  // unmapped addresses still ack and read zero, so the master never hangs
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      wb_dat_out <= rd_data;
    end
  end

endmodule // rsc_core
`default_nettype wire

// *** rsc_pkg.sv ***
/*
  rsc_pkg: register map, field positions, reset values and counts for the
  smooth calibrator and timestamp block.
  assumes: a 32-bit classic Wishbone register bus and a single system clock.
*/
`default_nettype none
package rsc_pkg;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_CAL        = 8'h08;
  localparam logic [7:0]  OFS_PRESCALE   = 8'h0C;
  localparam logic [7:0]  OFS_STAMP_SUB  = 8'h10;
  localparam logic [7:0]  OFS_STAMP_TIME = 8'h14;
  localparam logic [7:0]  OFS_STAMP_DATE = 8'h18;
  localparam int          CTRL_STAMP_EN  = 0;
  localparam int          CTRL_IRQ_EN    = 1;
  localparam int          CTRL_TAMP_STAMP = 2;
  localparam int          CTRL_INIT      = 3;
  localparam int          CTRL_FALL      = 4;
  localparam int          STS_INIT       = 0;
  localparam int          STS_RECAL      = 1;
  localparam int          STS_FLAG       = 2;
  localparam int          STS_OVF        = 3;
  localparam int          CAL_MASK_LSB   = 0;
  localparam int          CAL_W16        = 13;
  localparam int          CAL_W8         = 14;
  localparam int          CAL_INSERT     = 15;
  localparam int          MASK_W         = 9;
  localparam int          CAL_CNT_W      = 20;
  localparam int          INSERT_SHIFT   = 11;
  localparam int          ASYNC_W        = 7;
  localparam logic [6:0]  ASYNC_DIV_RST  = 7'h7F;
  localparam logic [6:0]  INSERT_MIN_DIV = 7'h03;
  localparam logic [4:0]  CTRL_RST       = 5'h00;
  localparam logic [1:0]  STAMP_SYNC_TK  = 2'h2;
  localparam logic [1:0]  RECAL_LOAD_TK  = 2'h2;
  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_WAIT = 2'b10
  } rsc_ts_state_type;
endpackage
`default_nettype wire

// *** rsc_core_sva.sv ***
/* rsc_core_sva: bus, read-field and pulse-shape assertions for rsc_core.
   assumes: bound to rsc_core, one clock, asynchronous active-low reset. */
`default_nettype none
module rsc_core_sva
  import rsc_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic          clk_sys_in,
  input wire logic          rst_b_in,
  input wire logic          wb_cyc_in,
  input wire logic          wb_stb_in,
  input wire logic          wb_we_in,
  input wire logic [AW-1:0] wb_adr_in,
  input wire logic [31:0]   wb_dat_out,
  input wire logic          wb_ack_out,
  input wire logic          stamp_irq_out,
  input wire logic          kernel_pulse_out,
  input wire logic          async_prescaler_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence rd_s(logic [AW-1:0] a);
    wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in && wb_adr_in == a;
  endsequence
  AST_ACK_ONE: assert property (req_s |=> wb_ack_out) else $error("ack late");
  AST_ACK_DROP: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  AST_ACK_IDLE: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out) else $error("ack without request");
  AST_UNMAPPED: assert property (req_s ##0 (!wb_we_in && wb_adr_in >= AW'(8'h1C)) |=> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  AST_CAL_RSV: assert property (rd_s(OFS_CAL) |=> wb_dat_out[31:16] == 16'h0 && wb_dat_out[12:9] == 4'h0)
    else $error("cal reserved bits set");
  AST_CAL_FORCED: assert property (rd_s(OFS_CAL) |=>
    !(wb_dat_out[CAL_W16] && wb_dat_out[0]) && !(wb_dat_out[CAL_W8] && wb_dat_out[1:0] != 2'h0))
    else $error("forced mask bits read set");
  AST_PRE_RSV: assert property (rd_s(OFS_PRESCALE) |=> wb_dat_out[31:7] == 25'h0) else $error("divider rsv set");
  AST_IRQ_PULSE: assert property (stamp_irq_out |=> !stamp_irq_out) else $error("irq too long");
  AST_INSERT_PAIR: assert property (kernel_pulse_out ##1 kernel_pulse_out |=> !kernel_pulse_out)
    else $error("three pulses in a row");
  AST_TICK_PULSE: assert property (async_prescaler_clock_out |=> !async_prescaler_clock_out)
    else $error("tick too long");
endmodule // rsc_core_sva
bind rsc_core rsc_core_sva #(.AW(AW)) i_sva (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .stamp_irq_out(stamp_irq_out), .kernel_pulse_out(kernel_pulse_out),
  .async_prescaler_clock_out(async_prescaler_clock_out));
`default_nettype wire

// *** rsc_core_test.sv ***
/* rsc_core_test: self-checking bench for rsc_core over classic Wishbone.
   assumes: rsc_pkg map; the bench makes the kernel clock only while it needs pulses. */
`default_nettype none
module rsc_core_test
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        k_clk = 1'b0;
  logic        pin = 1'b0;
  logic        tamper = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [15:0] sub = 16'h1234;
  logic [31:0] tim = 32'h00123456;
  logic [31:0] dat = 32'h00250317;
  logic [31:0] rdat;
  logic [31:0] rd_q;
  logic        ack;
  logic        irq;
  logic        kp;
  logic        tick;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          kp_cnt = 0;
  int          tick_cnt = 0;
  int          irq_cnt = 0;
  always #5 clk = ~clk;
  rsc_core i_dut (.clk_sys_in(clk), .rst_b_in(rst_b), .rtc_kernel_clock_in(k_clk), .stamp_pin_in(pin),
    .tamper_event_in(tamper), .cal_subsec_in(sub), .cal_time_in(tim), .cal_date_in(dat), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .stamp_irq_out(irq), .kernel_pulse_out(kp), .async_prescaler_clock_out(tick));
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // run budget is about 50k cycles; the ceiling leaves room but cuts a hang
  always @(posedge clk) begin
    cycles++;
    if (kp === 1'b1) kp_cnt++;
    if (tick === 1'b1) tick_cnt++;
    if (irq === 1'b1) irq_cnt++;
    if (cycles > 80000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // tp raises a tamper event for the cycle whose closing edge carries the write
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic tp);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    // only the bench ceiling ends a wait for ack
    do begin
      @(posedge clk);
      if (ack !== 1'b1) tamper <= tp;
    end while (ack !== 1'b1);
    rd_q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    tamper <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 1'b0);
    chk(rd_q, exp);
  endtask
  // kernel clock 2 clk high, 2 low: fastest rate the 2-flop sync still sees
  task automatic kpulse(input int n);
    repeat (n) begin
      k_clk <= 1'b1;
      repeat (2) @(posedge clk);
      k_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic settle();
    int t0;
    int n;
    t0 = tick_cnt;
    n = 0;
    do begin
      kpulse(1);
      wb(1'b0, OFS_STATUS, 32'h0, 1'b0);
      n++;
    end while (rd_q[STS_RECAL] !== 1'b0 && n < 64);
    chk(32'(tick_cnt - t0 <= 3), 32'h1);
  endtask
  task automatic wflag();
    int n;
    n = 0;
    do begin
      kpulse(1);
      wb(1'b0, OFS_STATUS, 32'h0, 1'b0);
      n++;
    end while (rd_q[STS_FLAG] !== 1'b1 && n < 64);
  endtask
  task automatic t_reset();
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_CAL, 32'h0);
    rd(OFS_PRESCALE, {25'h0, ASYNC_DIV_RST});
    wb(1'b1, 8'h40, 32'hFFFFFFFF, 1'b0);
    rd(8'h40, 32'h0);
    $display("test reset values done");
  endtask
  task automatic t_cal();
    logic [31:0] cal [3] = '{32'h00008000, 32'h00000100, 32'h00008100};
    int          len [3] = '{2048, 4096, 4096};
    int          c;
    // shadow writes go in init mode so that none lands while a recalibration is pending
    wb(1'b1, OFS_PRESCALE, 32'h2, 1'b0);
    wb(1'b1, OFS_CTRL, 32'h8, 1'b0);
    wb(1'b1, OFS_CAL, 32'h8000, 1'b0);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_CAL, 32'h0);
    wb(1'b1, OFS_CAL, 32'h21FF, 1'b0);
    rd(OFS_CAL, 32'h21FE);
    wb(1'b1, OFS_CAL, 32'h41FF, 1'b0);
    rd(OFS_CAL, 32'h41FC);
    wb(1'b1, OFS_CTRL, 32'h0, 1'b0);
    wb(1'b1, OFS_PRESCALE, 32'h3, 1'b0);
    wb(1'b1, OFS_CAL, 32'h0, 1'b0);
    rd(OFS_STATUS, 32'h2);
    settle();
    // each window nets one slot: one insert in 2048, one mask in 4096, or two inserts and one mask in 4096
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, OFS_CAL, cal[i], 1'b0);
      settle();
      c = kp_cnt;
      kpulse(len[i]);
      repeat (4) @(posedge clk);
      chk(32'(kp_cnt - c), 32'(len[i] + (i == 1 ? -1 : 1)));
    end
    // an insert already active is dropped once the divider falls below 3
    wb(1'b1, OFS_CAL, 32'h00008000, 1'b0);
    settle();
    wb(1'b1, OFS_PRESCALE, 32'h2, 1'b0);
    c = kp_cnt;
    kpulse(2048);
    repeat (4) @(posedge clk);
    chk(32'(kp_cnt - c), 32'h00000800);
    wb(1'b1, OFS_PRESCALE, 32'h3, 1'b0);
    $display("test calibration done");
  endtask
  task automatic t_stamp();
    int i0;
    int t0;
    wb(1'b1, OFS_CAL, 32'h0, 1'b0);
    settle();
    wb(1'b1, OFS_CTRL, 32'h7, 1'b0);
    i0 = irq_cnt;
    t0 = tick_cnt;
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    tamper <= 1'b1;
    @(posedge clk);
    tamper <= 1'b0;
    rd(OFS_STATUS, 32'h8);
    tim <= 32'h00130000;
    dat <= 32'h00260401;
    wflag();
    chk(32'(tick_cnt - t0), 32'h2);
    rd(OFS_STATUS, 32'hC);
    rd(OFS_STAMP_SUB, 32'h1234);
    rd(OFS_STAMP_TIME, 32'h00123456);
    rd(OFS_STAMP_DATE, 32'h00250317);
    wb(1'b1, OFS_STATUS, 32'h0, 1'b0);
    rd(OFS_STATUS, 32'h0);
    pin <= 1'b0;
    tamper <= 1'b1;
    @(posedge clk);
    tamper <= 1'b0;
    wflag();
    wb(1'b1, OFS_STATUS, 32'h0, 1'b1);
    rd(OFS_STATUS, 32'hC);
    rd(OFS_STAMP_TIME, 32'h00130000);
    // falling-edge select with interrupts off: a rising pin edge must not stamp
    wb(1'b1, OFS_STATUS, 32'h0, 1'b0);
    wb(1'b1, OFS_CTRL, 32'h11, 1'b0);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_STATUS, 32'h0);
    tim <= 32'h00140000;
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    wflag();
    rd(OFS_STATUS, 32'h4);
    rd(OFS_STAMP_TIME, 32'h00140000);
    chk(32'(irq_cnt - i0), 32'h2);
    $display("test timestamp done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cal();
    t_stamp();
    results();
  end
endmodule // rsc_core_test
`default_nettype wire
